// File: src/ros_pkg.sv
package ros_pkg;
  // time base
  localparam int unsigned CLK_HZ       = 100_000_000;
  localparam int unsigned STAMP_RES_MS = 1;
  localparam int unsigned CYC_PER_MS   = CLK_HZ / 1000 * STAMP_RES_MS;
  localparam int unsigned TICK_MS      = 5;
  localparam int unsigned PREF_WIN_MS  = 20;
  localparam int unsigned PREF_OFS_MS  = 20;
  localparam int unsigned PREF_WIN_TK  = PREF_WIN_MS / TICK_MS;
  localparam int unsigned HIST_DEPTH   = (PREF_WIN_MS + PREF_OFS_MS) / TICK_MS;
  localparam int unsigned N_GROUPS     = 8;
  localparam int unsigned MAG_W        = 16;
  localparam logic [6:0]  RST_NUM      = 7'h61;
  localparam logic [6:0]  RST_DEN      = 7'h64;
  // input selection and magnitude codes
  localparam logic [1:0] SEL_COARSE   = 2'h1;
  localparam logic [1:0] SEL_SENS     = 2'h2;
  localparam logic [1:0] SEL_COMPUTED = 2'h3;
  localparam logic [1:0] MAG_RMS      = 2'h1;
  localparam logic [1:0] MAG_TRMS     = 2'h2;
  localparam logic [1:0] MAG_PP       = 2'h3;
  // timing modes and curve families
  localparam logic [1:0] MODE_INSTANT = 2'h0;
  localparam logic [1:0] MODE_DT      = 2'h1;
  localparam logic [1:0] MODE_IDMT    = 2'h2;
  localparam logic [1:0] CURVE_IEC    = 2'h0;
  localparam logic [1:0] CURVE_ANSI   = 2'h1;
  localparam logic [1:0] CURVE_CUSTOM = 2'h2;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_STATUS   = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
  localparam logic [7:0] OFS_CNT_STRT = 8'h10;
  localparam logic [7:0] OFS_CNT_TRIP = 8'h14;
  localparam logic [7:0] OFS_CNT_BLK  = 8'h18;
  localparam logic [7:0] OFS_PREFAULT = 8'h1C;
  localparam logic [7:0] OFS_MAG      = 8'h20;
  localparam logic [1:0] GRP_PAGE     = 2'h1;
  // field positions
  localparam int unsigned CTRL_SEL_LSB  = 0;
  localparam int unsigned CTRL_MAG_LSB  = 2;
  localparam int unsigned CTRL_CLR_BIT  = 8;
  localparam int unsigned TIM_MODE_LSB  = 0;
  localparam int unsigned TIM_CURVE_LSB = 2;
  localparam int unsigned TIM_DLY_LSB   = 16;
  // reset values
  localparam logic [1:0]       SEL_RST = SEL_COARSE;
  localparam logic [1:0]       MAGC_RST = MAG_RMS;
  localparam logic [MAG_W-1:0] THR_RST = 16'h0100;
  localparam logic [31:0]      TIM_RST = 32'h0000_0000;
  // event bit positions
  localparam int unsigned EV_START_ON  = 0;
  localparam int unsigned EV_START_OFF = 1;
  localparam int unsigned EV_TRIP_ON   = 2;
  localparam int unsigned EV_TRIP_OFF  = 3;
  localparam int unsigned EV_BLK_ON    = 4;
  localparam int unsigned EV_BLK_OFF   = 5;

  typedef enum logic [1:0] {COND_NORMAL, COND_START, COND_TRIP, COND_BLOCKED} ros_cond_t;

  typedef struct packed {
    logic [MAG_W-1:0] coarse_input_rms;
    logic [MAG_W-1:0] coarse_input_true_rms;
    logic [MAG_W-1:0] sensitive_input_rms;
    logic [MAG_W-1:0] sensitive_input_true_rms;
    logic [MAG_W-1:0] computed_residual_current;
  } ros_meas_t;

  typedef struct packed {
    logic [31:0] stamp_ms;
    logic [5:0]  bits;
  } ros_event_t;
endpackage : ros_pkg

// File: src/ros_stage.sv
`timescale 1ns/100ps
// Operation
// - operating current from coarse, sensitive or computed residual, set by configuration
// - measured inputs use RMS, true RMS or peak-to-peak magnitude
// - peak-to-peak is taken from raw samples directly
// - every magnitude source refreshes once per 5 ms tick
// - eight parameter sets, active one chosen by one common selector
// - set and blocking changes apply live without restart
// - instant or delayed mode; delayed is definite or inverse with IEC/ANSI/custom
// - saturation check keeps start and operate working under CT saturation for coarse and sensitive inputs, not for computed residual
// - select, process, saturation, compare, block, delay, output in order
// - timestamped ON and OFF events for start, trip and blocked
// - instant mode emits start and trip events with same stamp
// - event stamps have one millisecond resolution
// - cumulative start, trip, blocked counters, clearable on request
// - pre-fault is 20 ms average ending 20 ms before start or trip
// - input selection codes 1 coarse, 2 sensitive, 3 computed; default 1
// - pick-up above threshold, release below 97 percent of threshold
// - start only while unblocked; pick-up alone is not start
// - block sampled each processing cycle; unblocked pick-up starts delay
module ros_stage
  import ros_pkg::*;
#(
  parameter int unsigned CYC_MS = CYC_PER_MS
) (
  // clock and reset
  input  wire logic              hclk,
  input  wire logic              hresetn,
  // ahb-lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic              hready,
  input  wire logic [31:0]       hwdata,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  // measurements from pre-processing
  input  wire ros_meas_t         meas,
  input  wire logic              sample_valid,
  input  wire logic [MAG_W-1:0]  coarse_sample,
  input  wire logic [MAG_W-1:0]  sensitive_sample,
  // external pins
  input  wire logic              block_in,
  input  wire logic              ct_saturation,
  input  wire logic [2:0]        group_sel,
  // stage outputs
  output logic                   start_out,
  output logic                   trip_out,
  output logic                   blocked_out,
  output logic                   irq,
  output logic                   ev_valid,
  output ros_event_t             ev
);

  function automatic logic [MAG_W-1:0] pp_of(input logic [MAG_W-1:0] mx,
                                             input logic [MAG_W-1:0] mn);
    logic signed [MAG_W:0] d;
    d = $signed({mx[MAG_W-1], mx}) - $signed({mn[MAG_W-1], mn});
    if (d <= 0) return '0;
    if (d[MAG_W-1 +: 2] != 2'h0) return '1;
    return d[MAG_W-1:0];
  endfunction : pp_of

  function automatic logic [MAG_W-1:0] pick(input logic [1:0] code,
                                            input logic [MAG_W-1:0] rms,
                                            input logic [MAG_W-1:0] trms,
                                            input logic [MAG_W-1:0] pp);
    case (code)
      MAG_TRMS: return trms;
      MAG_PP:   return pp;
      default:  return rms;
    endcase
  endfunction : pick

  function automatic logic below_release(input logic [MAG_W-1:0] m,
                                         input logic [MAG_W-1:0] t);
    return (23'(m) * 23'(RST_DEN)) < (23'(t) * 23'(RST_NUM));
  endfunction : below_release

  function automatic logic [MAG_W-1:0] s_max(input logic [MAG_W-1:0] a,
                                             input logic [MAG_W-1:0] b);
    return ($signed(a) > $signed(b)) ? a : b;
  endfunction : s_max

  function automatic logic [MAG_W-1:0] s_min(input logic [MAG_W-1:0] a,
                                             input logic [MAG_W-1:0] b);
    return ($signed(a) < $signed(b)) ? a : b;
  endfunction : s_min

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [4:0] sync1_r;
  logic [4:0] sync2_r;
  wire        blk_s = sync2_r[0];
  wire        sat_s = sync2_r[1];
  wire  [2:0] grp_s = sync2_r[4:2];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= {group_sel, ct_saturation, block_in};
      sync2_r <= sync1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // millisecond stamp and 5 ms processing tick
  logic [31:0] ms_cyc_r;
  logic [31:0] stamp_r;
  logic [2:0]  tk_ms_r;
  wire         ms_pulse = (ms_cyc_r == 32'(CYC_MS - 1));
  wire         tick     = ms_pulse && (tk_ms_r == 3'(TICK_MS - 1));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ms_cyc_r <= '0;
      stamp_r  <= '0;
      tk_ms_r  <= '0;
    end else begin
      ms_cyc_r <= ms_pulse ? 32'h0 : ms_cyc_r + 32'h1;
      stamp_r  <= ms_pulse ? stamp_r + 32'h1 : stamp_r;
      tk_ms_r  <= tick ? 3'h0 : (ms_pulse ? tk_ms_r + 3'h1 : tk_ms_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // raw-sample peak trackers
  logic [MAG_W-1:0] cmax_r, cmin_r, smax_r, smin_r;
  localparam logic [MAG_W-1:0] NEG_FULL = {1'b1, {(MAG_W-1){1'b0}}};
  localparam logic [MAG_W-1:0] POS_FULL = {1'b0, {(MAG_W-1){1'b1}}};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmax_r <= NEG_FULL;
      cmin_r <= POS_FULL;
      smax_r <= NEG_FULL;
      smin_r <= POS_FULL;
    end else if (tick) begin
      cmax_r <= NEG_FULL;
      cmin_r <= POS_FULL;
      smax_r <= NEG_FULL;
      smin_r <= POS_FULL;
    end else if (sample_valid) begin
      cmax_r <= s_max(cmax_r, coarse_sample);
      cmin_r <= s_min(cmin_r, coarse_sample);
      smax_r <= s_max(smax_r, sensitive_sample);
      smin_r <= s_min(smin_r, sensitive_sample);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers
  logic [1:0]       sel_r, magc_r;
  logic [MAG_W-1:0] thr_mem [N_GROUPS];
  logic [31:0]      tim_mem [N_GROUPS];
  logic [2:0]       irq_stat_r, irq_mask_r;

  // input selection, magnitude processing and saturation check
  wire [MAG_W-1:0] coarse_input_peak_peak    = pp_of(cmax_r, cmin_r);
  wire [MAG_W-1:0] sensitive_input_peak_peak = pp_of(smax_r, smin_r);
  wire [MAG_W-1:0] coarse_mag = pick(magc_r, meas.coarse_input_rms,
                                     meas.coarse_input_true_rms, coarse_input_peak_peak);
  wire [MAG_W-1:0] sens_mag   = pick(magc_r, meas.sensitive_input_rms,
                                     meas.sensitive_input_true_rms,
                                     sensitive_input_peak_peak);
  wire [MAG_W-1:0] raw_mag = (sel_r == SEL_SENS)     ? sens_mag :
                             (sel_r == SEL_COMPUTED) ? meas.computed_residual_current :
                                                       coarse_mag;
  wire [MAG_W-1:0] pp_sel  = (sel_r == SEL_SENS) ? sensitive_input_peak_peak
                                                 : coarse_input_peak_peak;
  wire [MAG_W-1:0] half_pp = pp_sel >> 1;
  // a saturated ct squashes rms, the raw peak survives
  wire             use_pk  = sat_s && (sel_r != SEL_COMPUTED) && (half_pp > raw_mag);
  wire [MAG_W-1:0] proc_mag = use_pk ? half_pp : raw_mag;

  ////////////////////////////////////////////////////////////////////////////
  // threshold, blocking and delay evaluation, one cycle after the tick
  logic [MAG_W-1:0] mag_r;
  logic             proc_r;
  logic             pickup_r;
  logic [15:0]      dt_cnt_r;
  logic [31:0]      acc_r;
  logic [MAG_W-1:0] hist_r [HIST_DEPTH];
  logic [MAG_W-1:0] prefault_r;

  wire [MAG_W-1:0] thr      = thr_mem[grp_s];
  wire [31:0]      tim      = tim_mem[grp_s];
  wire [1:0]       mode     = tim[TIM_MODE_LSB +: 2];
  wire [1:0]       curve    = tim[TIM_CURVE_LSB +: 2];
  wire [15:0]      delay    = tim[TIM_DLY_LSB +: 16];
  wire             pu_nxt   = pickup_r ? !below_release(mag_r, thr) : (mag_r > thr);
  wire             start_nxt = pu_nxt && !blk_s;
  wire             blk_nxt  = pu_nxt && blk_s;
  wire [MAG_W-1:0] excess   = (mag_r > thr) ? mag_r - thr : '0;
  wire [31:0]      acc_nxt  = acc_r + (32'(excess) >> ((curve == CURVE_IEC)  ? 0 :
                                                       (curve == CURVE_ANSI) ? 1 : 2));
  wire [15:0]      dt_nxt   = dt_cnt_r + 16'h1;
  wire             expired  = (mode == MODE_INSTANT) ||
                              ((mode == MODE_DT) && (dt_nxt >= delay)) ||
                              ((mode == MODE_IDMT) && (acc_nxt >= {delay, 16'h0000}));
  wire             trip_nxt = start_nxt && (trip_out || expired);
  wire [5:0]       ev_bits  = {blocked_out && !blk_nxt, !blocked_out && blk_nxt,
                               trip_out && !trip_nxt, !trip_out && trip_nxt,
                               start_out && !start_nxt, !start_out && start_nxt};
  wire             fault_on = ev_bits[EV_START_ON] || ev_bits[EV_TRIP_ON];

  logic [MAG_W+1:0] pref_sum;
  always_comb begin
    pref_sum = '0;
    for (int i = PREF_WIN_TK; i < HIST_DEPTH; i++) begin
      pref_sum = pref_sum + (MAG_W+2)'(hist_r[i]);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mag_r  <= '0;
      proc_r <= 1'b0;
    end else begin
      proc_r <= tick;
      mag_r  <= tick ? proc_mag : mag_r;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pickup_r    <= 1'b0;
      start_out   <= 1'b0;
      trip_out    <= 1'b0;
      blocked_out <= 1'b0;
      dt_cnt_r    <= '0;
      acc_r       <= '0;
    end else if (proc_r) begin
      pickup_r    <= pu_nxt;
      start_out   <= start_nxt;
      trip_out    <= trip_nxt;
      blocked_out <= blk_nxt;
      dt_cnt_r    <= start_nxt ? dt_nxt : 16'h0;
      acc_r       <= start_nxt ? acc_nxt : 32'h0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < HIST_DEPTH; i++) hist_r[i] <= '0;
      prefault_r <= '0;
    end else if (proc_r) begin
      hist_r[0] <= mag_r;
      for (int i = 1; i < HIST_DEPTH; i++) hist_r[i] <= hist_r[i-1];
      if (fault_on) prefault_r <= pref_sum[MAG_W+1:2];
    end
  end

  // events carry one stamp per processing cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ev_valid <= 1'b0;
      ev       <= '0;
    end else begin
      ev_valid    <= proc_r && (ev_bits != 6'h00);
      ev.bits     <= proc_r ? ev_bits : 6'h00;
      ev.stamp_ms <= proc_r ? stamp_r : ev.stamp_ms;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ahb-lite slave, zero wait states
  logic        wr_pend_r;
  logic [7:0]  wr_addr_r;
  logic [15:0] cnt_start_r, cnt_trip_r, cnt_blk_r;
  wire         acc_ok  = hsel && htrans[1] && hready;
  wire         grp_hit = (haddr[7:6] == GRP_PAGE);
  wire         wgrp    = (wr_addr_r[7:6] == GRP_PAGE);
  wire [2:0]   wgi     = wr_addr_r[5:3];
  wire         wr_ctrl = wr_pend_r && (wr_addr_r == OFS_CTRL);
  wire         cnt_clr = wr_ctrl && hwdata[CTRL_CLR_BIT];
  wire [2:0]   w1c     = (wr_pend_r && (wr_addr_r == OFS_IRQ_STAT)) ? hwdata[2:0] : 3'h0;
  wire [2:0]   irq_set = proc_r ? {ev_bits[EV_BLK_ON], ev_bits[EV_TRIP_ON],
                                   ev_bits[EV_START_ON]} : 3'h0;
  wire [1:0]   w_sel   = hwdata[CTRL_SEL_LSB +: 2];
  wire [1:0]   w_magc  = hwdata[CTRL_MAG_LSB +: 2];
  ros_cond_t   cond;
  assign cond = trip_out ? COND_TRIP : start_out ? COND_START :
                blocked_out ? COND_BLOCKED : COND_NORMAL;

  logic [31:0] rd_word;
  always_comb begin
    rd_word = 32'h0;
    if (grp_hit) begin
      rd_word = haddr[2] ? tim_mem[haddr[5:3]] : 32'(thr_mem[haddr[5:3]]);
    end else begin
      case (haddr[7:0])
        OFS_CTRL:     rd_word = {28'h0, magc_r, sel_r};
        OFS_STATUS:   rd_word = {25'h0, grp_s, pickup_r, blocked_out, trip_out, start_out};
        OFS_IRQ_STAT: rd_word = {29'h0, irq_stat_r};
        OFS_IRQ_MASK: rd_word = {29'h0, irq_mask_r};
        OFS_CNT_STRT: rd_word = {16'h0, cnt_start_r};
        OFS_CNT_TRIP: rd_word = {16'h0, cnt_trip_r};
        OFS_CNT_BLK:  rd_word = {16'h0, cnt_blk_r};
        OFS_PREFAULT: rd_word = 32'(prefault_r);
        OFS_MAG:      rd_word = {14'h0, cond, mag_r};
        default:      rd_word = 32'h0;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= '0;
      hrdata    <= '0;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      wr_pend_r <= acc_ok && hwrite;
      wr_addr_r <= acc_ok ? haddr[7:0] : wr_addr_r;
      hrdata    <= (acc_ok && !hwrite) ? rd_word : 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sel_r      <= SEL_RST;
      magc_r     <= MAGC_RST;
      irq_mask_r <= '0;
      for (int i = 0; i < N_GROUPS; i++) begin
        thr_mem[i] <= THR_RST;
        tim_mem[i] <= TIM_RST;
      end
    end else begin
      if (wr_ctrl && w_sel != 2'h0) sel_r <= w_sel;
      if (wr_ctrl && w_magc != 2'h0) magc_r <= w_magc;
      if (wr_pend_r && wr_addr_r == OFS_IRQ_MASK) irq_mask_r <= hwdata[2:0];
      if (wr_pend_r && wgrp && !wr_addr_r[2]) thr_mem[wgi] <= hwdata[MAG_W-1:0];
      if (wr_pend_r && wgrp && wr_addr_r[2]) tim_mem[wgi] <= hwdata;
    end
  end

  // counting wins over a clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_start_r <= '0;
      cnt_trip_r  <= '0;
      cnt_blk_r   <= '0;
      irq_stat_r  <= '0;
      irq         <= 1'b0;
    end else begin
      cnt_start_r <= (cnt_clr ? 16'h0 : cnt_start_r) + 16'(irq_set[0]);
      cnt_trip_r  <= (cnt_clr ? 16'h0 : cnt_trip_r) + 16'(irq_set[1]);
      cnt_blk_r   <= (cnt_clr ? 16'h0 : cnt_blk_r) + 16'(irq_set[2]);
      irq_stat_r  <= (irq_stat_r & ~w1c) | irq_set;
      irq         <= |(irq_stat_r & irq_mask_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  int unsigned gap_r;
  logic        seen_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gap_r  <= 0;
      seen_r <= 1'b0;
    end else begin
      gap_r  <= tick ? 0 : gap_r + 1;
      seen_r <= seen_r | tick;
    end
  end

  chk_tick_period: assert property (
    @(posedge hclk) disable iff (!hresetn) (tick && seen_r) |-> (gap_r == CYC_MS * TICK_MS - 1))
    else $error("processing tick period wrong");
  chk_start_unblocked: assert property (
    @(posedge hclk) disable iff (!hresetn) start_out |-> !blocked_out)
    else $error("start and blocked together");
  chk_trip_with_start: assert property (
    @(posedge hclk) disable iff (!hresetn) trip_out |-> start_out)
    else $error("trip without start");
  chk_sel_encoding: assert property (
    @(posedge hclk) disable iff (!hresetn) sel_r != 2'h0)
    else $error("input selection code zero");
  chk_instant_same_stamp: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (proc_r && mode == MODE_INSTANT && start_nxt && !start_out)
      |=> (ev_valid && ev.bits[EV_START_ON] && ev.bits[EV_TRIP_ON]))
    else $error("instant start and trip events split");
  chk_start_event: assert property (
    @(posedge hclk) disable iff (!hresetn)
    $rose(start_out) |-> (ev_valid && ev.bits[EV_START_ON] && ev.stamp_ms == $past(stamp_r)))
    else $error("start rise without event");
  chk_hyst_hold: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (proc_r && pickup_r && !below_release(mag_r, thr)) |=> pickup_r)
    else $error("pickup released above reset ratio");
  chk_start_count: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ($rose(start_out) && !$past(cnt_clr)) |-> (cnt_start_r == $past(cnt_start_r) + 16'h1))
    else $error("start counter missed");
  chk_irq_level: assert property (
    @(posedge hclk) disable iff (!hresetn) irq == $past(|(irq_stat_r & irq_mask_r)))
    else $error("interrupt level wrong");

endmodule : ros_stage

// File: verification/residual_overcurrent_stage_tb.sv
`timescale 1ns/100ps
module residual_overcurrent_stage_tb;
  import ros_pkg::*;
  localparam int CYC  = 20;
  localparam int TICK = 5 * CYC;
  logic             hclk, hresetn, hsel, hwrite, block_in, hreadyout, hresp, irq, ev_valid;
  logic             start_out, trip_out, blocked_out, sample_valid, sat;
  logic [31:0]      haddr, hwdata, hrdata, rd;
  logic [1:0]       htrans;
  logic [2:0]       group_sel;
  logic [MAG_W-1:0] lvl, cs, ss;
  logic [5:0]       last_ev;
  ros_meas_t        meas;
  ros_event_t       ev;
  int               fail_count, check_count, cyc;
  logic [31:0]      cv[5] = '{32'h5, 32'h6, 32'h7, 32'h9, 32'hD};
  logic [31:0]      mv[5] = '{32'h80, 32'h40, 32'h20, 32'h81, 32'h100};

  ros_meas_model meas_model (.hclk(hclk), .lvl(lvl), .meas(meas), .sample_valid(sample_valid),
    .coarse_sample(cs), .sensitive_sample(ss));
  ros_stage #(.CYC_MS(CYC)) uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .meas(meas),
    .sample_valid(sample_valid), .coarse_sample(cs), .sensitive_sample(ss),
    .block_in(block_in), .ct_saturation(sat), .group_sel(group_sel),
    .start_out(start_out), .trip_out(trip_out), .blocked_out(blocked_out), .irq(irq),
    .ev_valid(ev_valid), .ev(ev));

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    if (ev_valid === 1'b1) last_ev <= ev.bits;
    cyc++;
    if (cyc == 10000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  //////////////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= a;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask : xfer
  task automatic rdchk(input string nm, input logic [31:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(nm, rd, exp);
  endtask : rdchk
  task automatic ticks(input int n);
    repeat (n * TICK) @(posedge hclk);
  endtask : ticks
  task automatic tally_and_finish();
    if (fail_count == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish
  //////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    {hresetn, hsel, hwrite, block_in, sat, htrans, haddr, hwdata, group_sel} = '0;
    {fail_count, check_count, cyc, last_ev} = '0;
    lvl = 16'h0080;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdchk("ctrl", 32'h00, 32'h5);
    rdchk("thr0", 32'h40, 32'h100);
    rdchk("mask", 32'h0C, 32'h0);
    rdchk("unmapped", 32'h3C, 32'h0);
    for (int i = 0; i < 5; i++) begin
      xfer(1'b1, 32'h00, cv[i]);
      ticks(2);
      rdchk("mag", 32'h20, mv[i]);
    end
    // sensitive rms is half the level, its raw peak-peak/2 is the full level
    sat <= 1'b1;
    xfer(1'b1, 32'h00, 32'h6);
    ticks(2);
    rdchk("sat", 32'h20, 32'h80);
    sat <= 1'b0;
    xfer(1'b1, 32'h00, 32'h5);
    xfer(1'b1, 32'h0C, 32'h7);
    lvl <= 16'h0200;
    ticks(2);
    rdchk("status", 32'h04, 32'hB);
    chk("ev", {26'h0, last_ev}, 32'h5);
    chk("irq", {31'h0, irq}, 32'h1);
    rdchk("cnt_start", 32'h10, 32'h1);
    rdchk("cnt_trip", 32'h14, 32'h1);
    xfer(1'b1, 32'h08, 32'h7);
    repeat (3) @(posedge hclk);
    chk("irq_clr", {31'h0, irq}, 32'h0);
    lvl <= 16'h00F9;
    ticks(2);
    chk("hold", {31'h0, start_out}, 32'h1);
    lvl <= 16'h00F8;
    ticks(2);
    chk("release", {31'h0, start_out}, 32'h0);
    chk("ev_off", {26'h0, last_ev}, 32'hA);
    block_in <= 1'b1;
    lvl <= 16'h0200;
    ticks(2);
    rdchk("blocked", 32'h04, 32'hC);
    chk("ev_blk", {26'h0, last_ev}, 32'h10);
    rdchk("cnt_blk", 32'h18, 32'h1);
    block_in <= 1'b0;
    ticks(2);
    rdchk("unblock", 32'h04, 32'hB);
    lvl <= 16'h0080;
    ticks(2);
    xfer(1'b1, 32'h00, 32'h105);
    rdchk("cnt_clr", 32'h10, 32'h0);
    group_sel <= 3'h3;
    xfer(1'b1, 32'h58, 32'h400);
    xfer(1'b1, 32'h5C, 32'h0003_0001);
    lvl <= 16'h0200;
    ticks(2);
    rdchk("group", 32'h04, 32'h30);
    lvl <= 16'h0500;
    for (int i = 0; i < 2 * TICK && start_out !== 1'b1; i++) @(posedge hclk);
    ticks(1);
    chk("dt_wait", {31'h0, trip_out}, 32'h0);
    ticks(1);
    chk("dt_trip", {31'h0, trip_out}, 32'h1);
    rdchk("cond", 32'h20, 32'h0002_0500);
    // steady history of one level, then a new start captures its average
    lvl <= 16'h0080;
    ticks(9);
    lvl <= 16'h0500;
    ticks(2);
    rdchk("prefault", 32'h1C, 32'h80);
    tally_and_finish();
  end
endmodule : residual_overcurrent_stage_tb

// File: verification/ros_meas_model.sv
`timescale 1ns/100ps
module ros_meas_model
  import ros_pkg::*;
(
  // clock
  input  wire logic             hclk,
  // level commanded by the bench
  input  wire logic [MAG_W-1:0] lvl,
  // measurement side
  output ros_meas_t             meas,
  output logic                  sample_valid,
  output logic      [MAG_W-1:0] coarse_sample,
  output logic      [MAG_W-1:0] sensitive_sample
);
  logic ph;
  initial begin
    ph = 1'b0;
    meas = '0;
    sample_valid = 1'b0;
    coarse_sample = '0;
    sensitive_sample = '0;
  end
  // rms sources differ per channel so a wrong selection shows; raw samples are equal on both
  always @(posedge hclk) begin
    ph <= ~ph;
    sample_valid <= 1'b1;
    meas <= {lvl, lvl + 16'h0001, lvl >> 1, lvl >> 1, lvl >> 2};
    coarse_sample <= ph ? lvl : -lvl;
    sensitive_sample <= ph ? lvl : -lvl;
  end
endmodule : ros_meas_model
